// ---- core/tbog_guard.sv ----
// break, main output enable, lock, reference clear and step switch logic
`timescale 1ns/10ps
`default_nettype none

module tbog_guard
    import tbog_pkg::*;
#(
    parameter int CHANNELS = 3
)(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire tbog_wb_req_t        wbReq,
    output logic                     wbAck,
    output logic [31:0]              wbDatOut,
    input  wire logic                break_pin,
    input  wire tbog_brk_src_t       brkSrc,
    input  wire logic                update_event,
    input  wire logic                trigger_input,
    input  wire logic                filtered_ext_trigger,
    input  wire logic [CHANNELS-1:0] reference_wave,
    output logic [CHANNELS-1:0]      main_output,
    output logic [CHANNELS-1:0]      compl_output,
    output logic [CHANNELS-1:0]      mainOutEn,
    output logic [CHANNELS-1:0]      complOutEn,
    output logic                     breakIrq,
    output logic                     stepSwitchIrq,
    output logic                     stepSwitchDmaReq
);

    localparam int MW = CHANNELS * CHAN_MODE_W;

    // configuration registers
    logic [CTRL_DT_W-1:0]  deadtime_field_r;
    logic [1:0]            lockLevel_r;
    logic                  lockWritten_r;
    logic                  idle_offstate_select_r;
    logic                  run_offstate_select_r;
    logic                  breakEnReq_r;
    logic                  breakPolReq_r;
    logic                  break_enable_r;
    logic                  break_polarity_r;
    logic                  auto_output_reenable_r;
    logic [CHANNELS-1:0]   idle_level_main_r;
    logic [CHANNELS-1:0]   idle_level_compl_r;
    logic [CHANNELS-1:0]   polMain_r;
    logic [CHANNELS-1:0]   polCompl_r;
    logic [MW-1:0]         modePre_r;
    logic [CHANNELS-1:0]   enPre_r;
    logic [CHANNELS-1:0]   enNPre_r;
    logic [CHANNELS-1:0]   ref_clear_enable_r;
    logic [MW-1:0]         modeAct_r;
    logic [CHANNELS-1:0]   enAct_r;
    logic [CHANNELS-1:0]   enNAct_r;
    logic                  break_flag_r;
    logic                  step_switch_flag_r;
    logic                  break_irq_enable_r;
    logic                  step_switch_irq_enable_r;
    logic                  step_switch_dma_enable_r;
    logic                  moeSet_r;
    logic [2:0]            brkSync_r;
    logic [2:0]            trgSync_r;
    logic [2:0]            etrSync_r;
    logic                  trgLevel_r;
    logic [2:0]            moeSync_r;
    logic [CTRL_DT_W-1:0]  dtCount_r;
    logic [CHANNELS-1:0]   refCleared_r;

    // bus decode
    logic wbHit;
    logic wbWr;
    logic locked;
    assign wbHit  = wbReq.cyc && wbReq.stb && !wbAck;
    assign wbWr   = wbHit && wbReq.we;
    assign locked = (lockLevel_r != LOCK_OFF);

    // break source and asynchronous request
    logic breakRaw;
    logic breakActive;
    logic moeAsync;
    assign breakRaw = (break_pin ^ ~break_polarity_r) | brkSrc.lockup
                    | brkSrc.supply_monitor_alarm | brkSrc.clock_fail_detect
                    | brkSrc.comparator;
    assign breakActive = break_enable_r && breakRaw;
    // break path into moeAsync is combinational, but the outputs only follow it on a core_clk edge
    assign moeAsync = moeSet_r && !breakActive;

    // synchronised break level, second and third stage both high
    logic breakSynced;
    assign breakSynced = brkSync_r[1] && brkSync_r[2];

    // main output enable state; set by software or update event, killed by break
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            moeSet_r <= 1'b0;
        else if (breakActive)
            moeSet_r <= 1'b0;
        else if (wbWr && wbReq.adr == REG_CTRL && wbReq.sel[1])
            moeSet_r <= wbReq.dat[CTRL_MOE];
        else if (auto_output_reenable_r && update_event && !moeSet_r)
            moeSet_r <= 1'b1;
    end

    // resync of the asynchronous enable into the readable bit
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            moeSync_r <= 3'h0;
        else
            moeSync_r <= {moeSync_r[1:0], moeAsync};
    end

    // pin inputs through three stages
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            brkSync_r  <= 3'h0;
            trgSync_r  <= 3'h0;
            etrSync_r  <= 3'h0;
            trgLevel_r <= 1'b0;
        end
        else
        begin
            brkSync_r <= {brkSync_r[1:0], breakActive};
            trgSync_r <= {trgSync_r[1:0], trigger_input};
            etrSync_r <= {etrSync_r[1:0], filtered_ext_trigger};
            if (trgSync_r[1] == trgSync_r[2])
                trgLevel_r <= trgSync_r[2];
        end
    end

    logic stepEvent;
    assign stepEvent = (wbWr && wbReq.adr == REG_EVGEN && wbReq.sel[0]
                        && wbReq.dat[EVG_STEP])
                     || (trgSync_r[1] && trgSync_r[2] && !trgLevel_r);

    // control register writes, lock protected except the AOE bit and the lock field
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            deadtime_field_r       <= '0;
            lockLevel_r            <= LOCK_OFF;
            lockWritten_r          <= 1'b0;
            idle_offstate_select_r <= 1'b0;
            run_offstate_select_r  <= 1'b0;
            breakEnReq_r           <= 1'b0;
            breakPolReq_r          <= 1'b0;
            auto_output_reenable_r <= 1'b0;
            idle_level_main_r      <= '0;
            idle_level_compl_r     <= '0;
            polMain_r              <= '0;
            polCompl_r             <= '0;
        end
        else if (wbWr && wbReq.adr == REG_CTRL)
        begin
            if (!locked)
            begin
                deadtime_field_r       <= wbReq.dat[CTRL_DT_LSB +: CTRL_DT_W];
                idle_offstate_select_r <= wbReq.dat[CTRL_IDLE_OFFSTATE_SELECT];
                run_offstate_select_r  <= wbReq.dat[CTRL_RUN_OFFSTATE_SELECT];
                breakEnReq_r           <= wbReq.dat[CTRL_BKE];
                breakPolReq_r          <= wbReq.dat[CTRL_BKP];
                idle_level_main_r      <= wbReq.dat[CTRL_IDLE_LSB +: CHANNELS];
                idle_level_compl_r     <= wbReq.dat[CTRL_IDLEN_LSB +: CHANNELS];
                polMain_r              <= wbReq.dat[CTRL_POL_LSB +: CHANNELS];
                polCompl_r             <= wbReq.dat[CTRL_POLN_LSB +: CHANNELS];
            end
            auto_output_reenable_r <= wbReq.dat[CTRL_AOE];
            // lock field takes only its first write after reset
            if (!lockWritten_r)
            begin
                lockLevel_r   <= wbReq.dat[CTRL_LOCK_LSB +: 2];
                lockWritten_r <= 1'b1;
            end
        end
    end

    // break enable and polarity become effective one cycle after the write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            break_enable_r   <= 1'b0;
            break_polarity_r <= 1'b0;
        end
        else
        begin
            break_enable_r   <= breakEnReq_r;
            break_polarity_r <= breakPolReq_r;
        end
    end

    // preload and shadow of channel configuration
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            modePre_r          <= '0;
            enPre_r            <= '0;
            enNPre_r           <= '0;
            ref_clear_enable_r <= '0;
            modeAct_r          <= '0;
            enAct_r            <= '0;
            enNAct_r           <= '0;
        end
        else
        begin
            if (wbWr && wbReq.adr == REG_CHAN)
            begin
                if (!locked)
                    modePre_r <= wbReq.dat[CHAN_MODE_LSB +: MW];
                enPre_r            <= wbReq.dat[CHAN_EN_LSB +: CHANNELS];
                enNPre_r           <= wbReq.dat[CHAN_ENN_LSB +: CHANNELS];
                ref_clear_enable_r <= wbReq.dat[CHAN_CE_LSB +: CHANNELS];
            end
            // all channels switch together on the step event
            if (stepEvent)
            begin
                modeAct_r <= modePre_r;
                enAct_r   <= enPre_r;
                enNAct_r  <= enNPre_r;
            end
        end
    end

    // flags: hardware set beats software clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            break_flag_r       <= 1'b0;
            step_switch_flag_r <= 1'b0;
        end
        else
        begin
            if (breakSynced)
                break_flag_r <= 1'b1;
            else if (wbWr && wbReq.adr == REG_STATUS && wbReq.dat[STAT_BRK])
                break_flag_r <= 1'b0;
            if (stepEvent)
                step_switch_flag_r <= 1'b1;
            else if (wbWr && wbReq.adr == REG_STATUS && wbReq.dat[STAT_STEP])
                step_switch_flag_r <= 1'b0;
        end
    end

    // interrupt and dma enables
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            break_irq_enable_r       <= 1'b0;
            step_switch_irq_enable_r <= 1'b0;
            step_switch_dma_enable_r <= 1'b0;
        end
        else if (wbWr && wbReq.adr == REG_IRQEN)
        begin
            break_irq_enable_r       <= wbReq.dat[IEN_BRK];
            step_switch_irq_enable_r <= wbReq.dat[IEN_STEP];
            step_switch_dma_enable_r <= wbReq.dat[IEN_STEP_DMA];
        end
    end

    // request outputs registered
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            breakIrq         <= 1'b0;
            stepSwitchIrq    <= 1'b0;
            stepSwitchDmaReq <= 1'b0;
        end
        else
        begin
            breakIrq         <= break_flag_r && break_irq_enable_r;
            stepSwitchIrq    <= step_switch_flag_r && step_switch_irq_enable_r;
            stepSwitchDmaReq <= stepEvent && step_switch_dma_enable_r;
        end
    end

    // dead-time after the enable drops, resync adds the synchroniser delay
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            dtCount_r <= '0;
        else if (moeSync_r[2])
            dtCount_r <= deadtime_field_r;
        else if (dtCount_r != '0)
            dtCount_r <= dtCount_r - 1'b1;
    end

    logic etrHigh;
    assign etrHigh = etrSync_r[1] && etrSync_r[2];

    // per channel reference clearing and output steering
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_ch
            logic [2:0] mode;
            logic       forced;
            logic       refW;
            logic       actM;
            logic       actN;
            logic       lvlM;
            logic       lvlN;
            assign mode   = modeAct_r[ch*CHAN_MODE_W +: CHAN_MODE_W];
            assign forced = (mode == MODE_FORCE_LO) || (mode == MODE_FORCE_HI);

            // cleared level held until update event, forced modes exempt
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    refCleared_r[ch] <= 1'b0;
                else if (ref_clear_enable_r[ch] && etrHigh && !forced)
                    refCleared_r[ch] <= 1'b1;
                else if (update_event)
                    refCleared_r[ch] <= 1'b0;
            end

            assign refW = reference_wave[ch] && !refCleared_r[ch]
                          && !(ref_clear_enable_r[ch] && etrHigh && !forced);
            // both enabled: complement pair; only one: straight copy
            assign actM = enAct_r[ch] && refW;
            assign actN = enNAct_r[ch] && (enAct_r[ch] ? !refW : refW);
            // idle levels only once dead-time has elapsed, never both active
            assign lvlM = (dtCount_r == '0) && idle_level_main_r[ch]
                          && !(idle_level_compl_r[ch] && enNAct_r[ch]);
            assign lvlN = (dtCount_r == '0) && idle_level_compl_r[ch] && !lvlM;

            // outputs registered; the gate with moeAsync keeps the reaction fast
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    main_output[ch]  <= 1'b0;
                    compl_output[ch] <= 1'b0;
                    mainOutEn[ch]    <= 1'b0;
                    complOutEn[ch]   <= 1'b0;
                end
                else if (moeAsync && moeSync_r[2])
                begin
                    main_output[ch]  <= actM ^ polMain_r[ch];
                    compl_output[ch] <= actN ^ polCompl_r[ch];
                    mainOutEn[ch]    <= enAct_r[ch] || run_offstate_select_r;
                    complOutEn[ch]   <= enNAct_r[ch] || run_offstate_select_r;
                end
                else
                begin
                    main_output[ch]  <= lvlM ^ polMain_r[ch];
                    compl_output[ch] <= lvlN ^ polCompl_r[ch];
                    mainOutEn[ch]    <= idle_offstate_select_r
                                        && (enAct_r[ch] || enNAct_r[ch]);
                    complOutEn[ch]   <= idle_offstate_select_r
                                        && (enAct_r[ch] || enNAct_r[ch]);
                end
            end
        end
    endgenerate

    // read mux
    logic [31:0] rdData;
    always_comb
    begin
        rdData = RD_ZERO;
        unique case (wbReq.adr)
            REG_CTRL:
            begin
                rdData[CTRL_DT_LSB +: CTRL_DT_W]  = deadtime_field_r;
                rdData[CTRL_LOCK_LSB +: 2]        = lockLevel_r;
                rdData[CTRL_IDLE_OFFSTATE_SELECT]                 = idle_offstate_select_r;
                rdData[CTRL_RUN_OFFSTATE_SELECT]                 = run_offstate_select_r;
                rdData[CTRL_BKE]                  = break_enable_r;
                rdData[CTRL_BKP]                  = break_polarity_r;
                rdData[CTRL_AOE]                  = auto_output_reenable_r;
                rdData[CTRL_MOE]                  = moeSync_r[2];
                rdData[CTRL_IDLE_LSB +: CHANNELS]  = idle_level_main_r;
                rdData[CTRL_IDLEN_LSB +: CHANNELS] = idle_level_compl_r;
                rdData[CTRL_POL_LSB +: CHANNELS]   = polMain_r;
                rdData[CTRL_POLN_LSB +: CHANNELS]  = polCompl_r;
            end
            REG_CHAN:
            begin
                rdData[CHAN_MODE_LSB +: MW]      = modePre_r;
                rdData[CHAN_EN_LSB +: CHANNELS]  = enPre_r;
                rdData[CHAN_ENN_LSB +: CHANNELS] = enNPre_r;
                rdData[CHAN_CE_LSB +: CHANNELS]  = ref_clear_enable_r;
            end
            REG_STATUS:
            begin
                rdData[STAT_BRK]  = break_flag_r;
                rdData[STAT_STEP] = step_switch_flag_r;
            end
            REG_IRQEN:
            begin
                rdData[IEN_BRK]      = break_irq_enable_r;
                rdData[IEN_STEP]     = step_switch_irq_enable_r;
                rdData[IEN_STEP_DMA] = step_switch_dma_enable_r;
            end
            REG_ACTIVE:
            begin
                rdData[CHAN_MODE_LSB +: MW]      = modeAct_r;
                rdData[CHAN_EN_LSB +: CHANNELS]  = enAct_r;
                rdData[CHAN_ENN_LSB +: CHANNELS] = enNAct_r;
            end
            default:
                rdData = RD_ZERO;
        endcase
    end

    // single wait-free ack; unmapped reads return zero, writes are dropped
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wbAck    <= 1'b0;
            wbDatOut <= RD_ZERO;
        end
        else
        begin
            wbAck    <= wbHit;
            wbDatOut <= wbHit ? rdData : RD_ZERO;
        end
    end

endmodule

`default_nettype wire

// ---- core/tbog_pkg.sv ----
// shared constants, register map and carrier types for the break output guard
package tbog_pkg;

    // wishbone register word offsets (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;  // break / moe / lock / idle config
    localparam logic [7:0] REG_CHAN   = 8'h04;  // preloaded channel config
    localparam logic [7:0] REG_STATUS = 8'h08;  // flags, write one to clear
    localparam logic [7:0] REG_IRQEN  = 8'h0c;  // interrupt and dma enables
    localparam logic [7:0] REG_EVGEN  = 8'h10;  // event generation (write only)
    localparam logic [7:0] REG_ACTIVE = 8'h14;  // shadow config readback

    // REG_CTRL fields
    localparam int CTRL_DT_LSB     = 0;   // dead-time field, 8 bits
    localparam int CTRL_DT_W       = 8;
    localparam int CTRL_LOCK_LSB   = 8;   // two bit lock level
    localparam int CTRL_IDLE_OFFSTATE_SELECT       = 10;
    localparam int CTRL_RUN_OFFSTATE_SELECT       = 11;
    localparam int CTRL_BKE        = 12;
    localparam int CTRL_BKP        = 13;
    localparam int CTRL_AOE        = 14;
    localparam int CTRL_MOE        = 15;
    localparam int CTRL_IDLE_LSB   = 16;  // idle main levels, one per channel
    localparam int CTRL_IDLEN_LSB  = 20;  // idle complementary levels
    localparam int CTRL_POL_LSB    = 24;  // main polarity
    localparam int CTRL_POLN_LSB   = 28;  // complementary polarity

    // REG_CHAN fields, each field starting on a nibble boundary
    localparam int CHAN_MODE_LSB   = 0;   // 3 bit compare mode per channel
    localparam int CHAN_MODE_W     = 3;
    localparam int CHAN_EN_LSB     = 12;  // main enable per channel
    localparam int CHAN_ENN_LSB    = 16;  // complementary enable per channel
    localparam int CHAN_CE_LSB     = 20;  // reference clear enable per channel

    // REG_STATUS / REG_IRQEN / REG_EVGEN bits
    localparam int STAT_BRK        = 0;
    localparam int STAT_STEP       = 1;
    localparam int IEN_BRK         = 0;
    localparam int IEN_STEP        = 1;
    localparam int IEN_STEP_DMA    = 2;
    localparam int EVG_STEP        = 0;

    // compare mode encodings
    localparam logic [2:0] MODE_FORCE_LO = 3'h4;
    localparam logic [2:0] MODE_FORCE_HI = 3'h5;

    // lock levels
    localparam logic [1:0] LOCK_OFF    = 2'h0;

    localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

    // wishbone slave request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tbog_wb_req_t;

    // internal break sources
    typedef struct packed {
        logic lockup;
        logic supply_monitor_alarm;
        logic clock_fail_detect;
        logic comparator;
    } tbog_brk_src_t;

endpackage

// ---- tb/tbog_guard_properties.sv ----
// checker for the break output guard ports, with its bind
`timescale 1ns/10ps
`default_nettype none
module tbog_guard_chk
    import tbog_pkg::*;
#(
    parameter int CHANNELS = 3
)(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire tbog_wb_req_t        wbReq,
    input  wire logic                wbAck,
    input  wire logic [31:0]         wbDatOut,
    input  wire logic                break_pin,
    input  wire tbog_brk_src_t       brkSrc,
    input  wire logic [CHANNELS-1:0] main_output,
    input  wire logic [CHANNELS-1:0] compl_output,
    input  wire logic [CHANNELS-1:0] mainOutEn,
    input  wire logic [CHANNELS-1:0] complOutEn,
    input  wire logic                breakIrq,
    input  wire logic                stepSwitchIrq,
    input  wire logic                stepSwitchDmaReq
);
    logic [31:0] ctl_r;
    logic [2:0]  ien_r;
    logic        brkAct;
    // snooped control word; frozen once locked, as protected bits are
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst) ctl_r <= RD_ZERO;
        else if (wbAck && wbReq.we && wbReq.adr == REG_CTRL && ctl_r[9:8] == LOCK_OFF)
            ctl_r <= wbReq.dat;
    end
    // snooped interrupt and dma enables
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst) ien_r <= 3'h0;
        else if (wbAck && wbReq.we && wbReq.adr == REG_IRQEN) ien_r <= wbReq.dat[2:0];
    end
    assign brkAct = ctl_r[CTRL_BKE] && (break_pin == ctl_r[CTRL_BKP] || |brkSrc);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);
    ack_one_cycle_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
    ack_latency_a: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
        else $error("ack late");
    idle_data_a: assert property (!wbAck |-> wbDatOut == RD_ZERO) else $error("data leak");
    reset_quiet_a: assert property ($fell(rst) |-> !wbAck && mainOutEn == '0)
        else $error("not quiet after reset");
    brk_idle_en_a: assert property ((brkAct && !ctl_r[CTRL_IDLE_OFFSTATE_SELECT])[*3]
        |-> mainOutEn == '0 && complOutEn == '0) else $error("enable held in break");
    no_both_active_a: assert property (ctl_r[31:24] == 8'h00
        |-> (main_output & compl_output & mainOutEn & complOutEn) == '0) else $error("both on");
    brk_irq_a: assert property ((brkAct && ien_r[IEN_BRK])[*6] |-> breakIrq)
        else $error("break irq missing");
    dma_gate_a: assert property (stepSwitchDmaReq |-> ien_r[IEN_STEP_DMA])
        else $error("dma not enabled");
    dma_pulse_a: assert property (stepSwitchDmaReq |=> !stepSwitchDmaReq)
        else $error("dma too long");
    step_irq_a: assert property (stepSwitchDmaReq && ien_r[IEN_STEP] |-> ##[0:2] stepSwitchIrq)
        else $error("step irq missing");
    cover property (brkAct ##1 brkAct);
    cover property (stepSwitchDmaReq);
    cover property ($rose(breakIrq));
endmodule
bind tbog_guard tbog_guard_chk #(.CHANNELS(CHANNELS)) u_chk (.core_clk, .rst, .wbReq, .wbAck,
    .wbDatOut, .break_pin, .brkSrc, .main_output, .compl_output, .mainOutEn, .complOutEn,
    .breakIrq, .stepSwitchIrq, .stepSwitchDmaReq);
`default_nettype wire

// ---- tb/tbog_partner.sv ----
// far side model: power stage alarm and counter side waveforms
`timescale 1ns/10ps
`default_nettype none
module tbog_partner
#(
    parameter int CHANNELS = 3,
    parameter int PERIOD   = 16
)(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                alarm,
    output logic                     break_pin,
    output logic                     update_event,
    output logic [CHANNELS-1:0]      reference_wave
);
    logic [7:0] cnt_r;
    // free running period counter
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst) cnt_r <= 8'h00;
        else cnt_r <= (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
    end
    assign update_event = (cnt_r == 8'h00);  // one cycle per period
    // staggered duties so channels differ
    always_comb
    begin
        for (int i = 0; i < CHANNELS; i++)
            reference_wave[i] = cnt_r < 8'(4 * i + 4);
    end
    // alarm level from the drivers, active high on the pin
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst) break_pin <= 1'b0;
        else break_pin <= alarm;
    end
endmodule
`default_nettype wire

// ---- tb/tb_tbog_guard.sv ----
// self-checking bench for the break output guard
`timescale 1ns/10ps
`default_nettype none
module tb_tbog_guard
    import tbog_pkg::*;
();
    logic          core_clk = 1'b0;
    logic          rst = 1'b1;
    logic          alarm = 1'b0;
    logic          trigIn = 1'b0;
    logic          extTrig = 1'b0;  // fed straight, no prescaler stage
    tbog_wb_req_t  wbReq = '0;
    tbog_brk_src_t brkSrc = '0;
    logic [2:0]    reference_wave, main_output, compl_output, mainOutEn, complOutEn;
    logic [31:0]   wbDatOut, dt, chan;
    logic          wbAck, break_pin, update_event, breakIrq, stepSwitchIrq, stepSwitchDmaReq;
    logic [31:0]   expQ[$];
    int            seed = 32'ha3bb;
    int            failures = 0;
    int            tests_run = 0;
    tbog_guard u_dut (.core_clk, .rst, .wbReq, .wbAck, .wbDatOut, .break_pin, .brkSrc,
        .update_event, .trigger_input(trigIn), .filtered_ext_trigger(extTrig), .reference_wave,
        .main_output, .compl_output, .mainOutEn, .complOutEn, .breakIrq, .stepSwitchIrq,
        .stepSwitchDmaReq);
    tbog_partner u_far (.core_clk, .rst, .alarm, .break_pin, .update_event, .reference_wave);
    initial forever #12.5 core_clk = ~core_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one classic cycle; held until ack is sampled, then released
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge core_clk);
        wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        do @(posedge core_clk); while (wbAck !== 1'b1 && ++n < 50);
        if (n >= 50) failures++;
        wbReq <= '0;
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        expQ.push_back(exp);
        wb(1'b0, adr, RD_ZERO);
    endtask
    // read results are matched in order against the notes
    always @(posedge core_clk)
    begin
        if (wbAck === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0)
            check(wbDatOut, expQ.pop_front());
    end
    initial
    begin
        dt = 32'($random(seed)) & 32'h0000_00ff;
        chan = 32'h0017_71b6 | (32'($random(seed)) & 32'h0070_0000);
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(REG_CTRL, RD_ZERO);
        rd(8'h1c, RD_ZERO);
        wb(1'b1, REG_IRQEN, 32'h7);
        wb(1'b1, REG_CHAN, chan);
        rd(REG_ACTIVE, RD_ZERO);
        wb(1'b1, REG_EVGEN, 32'h1);
        rd(REG_ACTIVE, chan & 32'h0007_71ff);
        rd(REG_STATUS, 32'h2);
        wb(1'b1, REG_STATUS, 32'h2);
        trigIn <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(REG_STATUS, 32'h2);
        trigIn <= 1'b0;
        wb(1'b1, REG_STATUS, 32'h2);
        // the first control write also sets the lock level
        wb(1'b1, REG_CTRL, dt | 32'hb100);
        repeat (4) @(posedge core_clk);
        rd(REG_CTRL, dt | 32'hb100);
        check(32'(mainOutEn), 32'h7);
        alarm <= 1'b1;
        repeat (7) @(posedge core_clk);
        check(32'(mainOutEn), RD_ZERO);
        check(32'(breakIrq), 32'h1);
        wb(1'b1, REG_STATUS, 32'h1);
        wb(1'b1, REG_CTRL, dt | 32'hb000);
        repeat (4) @(posedge core_clk);
        rd(REG_STATUS, 32'h1);
        rd(REG_CTRL, dt | 32'h3100);
        alarm <= 1'b0;
        repeat (6) @(posedge core_clk);
        wb(1'b1, REG_STATUS, 32'h1);
        wb(1'b1, REG_CTRL, dt | 32'h7000);
        repeat (40) @(posedge core_clk);
        rd(REG_CTRL, dt | 32'hf100);
        // trigger high clears the reference of clear-enabled channels only
        extTrig <= 1'b1;
        repeat (5) @(posedge core_clk);
        check(32'(main_output & chan[22:20]), RD_ZERO);
        check(32'(compl_output & chan[22:20]), 32'(chan[22:20]));
        extTrig <= 1'b0;
        // a second lock write is ignored and protected fields stay frozen
        wb(1'b1, REG_CTRL, dt | 32'h7200);
        wb(1'b1, REG_CTRL, RD_ZERO);
        repeat (4) @(posedge core_clk);
        rd(REG_CTRL, dt | 32'h3100);
        // each internal source alone must raise the flag
        for (int i = 0; i < 4; i++)
        begin
            brkSrc <= tbog_brk_src_t'(4'h1 << i);
            repeat (6) @(posedge core_clk);
            brkSrc <= '0;
            repeat (6) @(posedge core_clk);
            rd(REG_STATUS, 32'h1);
            wb(1'b1, REG_STATUS, 32'h1);
        end
        repeat (4) @(posedge core_clk);
        finish_test();
    end
    // cut a hang well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
